// ---- fbod_pkg.sv ----
// Constants, pin bundles and request types for the host side of a parallel NOR flash bus.
// Assumes a 100 MHz host clock and an external level shifter that lifts the reset pin to
// the protect voltage while hv_en is high.
//
// Summary of operation
// - Reads hold chip select and output enable low, write enable high.
// - Writes hold write enable and chip select low, output enable high.
// - Sector protect: high voltage reset, write levels, A6 low, A1 high, A0 low.
// - Sector unprotect: same levels, A6 high, A1 high, A0 low.

package fbod_pkg;

  // ----------------------------------------------------------------
  // Widths and address bit positions
  // ----------------------------------------------------------------
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int CNT_W = 8;
  localparam int SYNC_W = DATA_W + 1;
  localparam int TOP_DQ = 15;
  localparam int LOW_BYTE_W = 8;
  localparam int PROT_A6 = 6;
  localparam int PROT_A1 = 1;
  localparam int PROT_A0 = 0;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Timing, in ns, and derived cycle counts
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int T_SETUP_NS = 10;
  localparam int T_ACC_NS = 70;
  localparam int T_WP_NS = 35;
  localparam int T_HOLD_NS = 20;
  localparam int T_RP_NS = 500;
  localparam int T_RH_NS = 50;

  function automatic logic [CNT_W-1:0] ns_to_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    if (c < 1)
    begin
      c = 1;
    end
    return CNT_W'(c);
  endfunction

  localparam logic [CNT_W-1:0] SETUP_CYC = ns_to_cyc(T_SETUP_NS);
  localparam logic [CNT_W-1:0] READ_CYC = CNT_W'(ns_to_cyc(T_ACC_NS) + CNT_W'(SYNC_STAGES));
  localparam logic [CNT_W-1:0] WP_CYC = ns_to_cyc(T_WP_NS);
  localparam logic [CNT_W-1:0] HOLD_CYC = ns_to_cyc(T_HOLD_NS);
  localparam logic [CNT_W-1:0] RP_CYC = ns_to_cyc(T_RP_NS);
  localparam logic [CNT_W-1:0] RH_CYC = ns_to_cyc(T_RH_NS);
  localparam logic [CNT_W-1:0] CNT_LAST = 8'h01;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FBOD_OP_READ = 3'h0,
    FBOD_OP_WRITE = 3'h1,
    FBOD_OP_PROTECT = 3'h2,
    FBOD_OP_UNPROTECT = 3'h3,
    FBOD_OP_RESET = 3'h4
  } fbod_op_t;

  typedef enum logic [5:0] {
    FBOD_ST_IDLE = 6'h01,
    FBOD_ST_SETUP = 6'h02,
    FBOD_ST_READ = 6'h04,
    FBOD_ST_WRITE = 6'h08,
    FBOD_ST_HOLD = 6'h10,
    FBOD_ST_RESET = 6'h20
  } fbod_state_t;

  typedef struct packed {
    fbod_op_t op;
    logic [ADDR_W-1:0] addr;
    logic byte_lsb;
    logic [DATA_W-1:0] wdata;
    logic byte_mode;
  } fbod_req_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic reset_n;
    logic hv_en;
    logic byte_n;
    logic protect_accel;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic [DATA_W-1:0] dq_oe;
  } fbod_pins_t;

endpackage

// ---- fbod_sync.sv ----
// Two-stage synchroniser, one generate lane per bit.
// Assumes each input bit is an asynchronous level from a pin.
`timescale 1ns/1ps
`default_nettype none

module fbod_sync #(
  parameter int WIDTH = fbod_pkg::SYNC_W
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Pin levels and synchronised copy
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import fbod_pkg::*;

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_lane
      always_ff @(posedge ref_clk_in)
      begin
        if (rst_in)
        begin
          stage1[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end
        else
        begin
          stage1[i] <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ---- fbod_host.sv ----
// Host controller that drives a parallel NOR flash through its bus pins.
// Assumes one request at a time from user logic on ref_clk_in, and that the board turns
// hv_en into the protect voltage on the flash reset pin.
`timescale 1ns/1ps
`default_nettype none

module fbod_host (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // User request
  input wire logic req_valid_in,
  output logic req_ready_out,
  input wire fbod_pkg::fbod_req_t req_in,
  // User answer
  output logic rsp_valid_out,
  output logic [fbod_pkg::DATA_W-1:0] rsp_rdata_out,
  // User levels
  input wire logic boot_unlock_in,
  output logic device_busy_out,
  // Flash pins
  output fbod_pkg::fbod_pins_t pins_out,
  input wire logic [fbod_pkg::DATA_W-1:0] dq_in,
  input wire logic ready_busy_n_in
);
  import fbod_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    fbod_state_t st;
    logic [CNT_W-1:0] cnt;
    fbod_op_t op;
    fbod_pins_t pins;
    logic [DATA_W-1:0] rdata;
    logic rsp_valid;
    logic busy;
    logic [1:0] sync_fill;
  } fbod_host_t;

  fbod_host_t s;
  fbod_host_t next_s;
  logic [SYNC_W-1:0] sync_v;
  logic [DATA_W-1:0] dq_sync;
  logic ready_sync;
  logic cnt_done;
  logic [ADDR_W-1:0] prot_addr;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  fbod_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .async_in({ready_busy_n_in, dq_in}),
    .sync_out(sync_v)
  );

  assign dq_sync = sync_v[DATA_W-1:0];
  assign ready_sync = sync_v[DATA_W];
  assign cnt_done = (s.cnt == CNT_LAST);

  // Protect and unprotect share A1 high and A0 low; A6 picks the direction
  always_comb
  begin
    prot_addr = req_in.addr;
    prot_addr[PROT_A6] = (req_in.op == FBOD_OP_UNPROTECT);
    prot_addr[PROT_A1] = 1'b1;
    prot_addr[PROT_A0] = 1'b0;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.rsp_valid = 1'b0;
    // Busy is active low on the pin; the cleared synchroniser would read as busy,
    // so status is held off until both stages carry real pin levels
    next_s.sync_fill = {s.sync_fill[0], 1'b1};
    next_s.busy = s.sync_fill[1] & ~ready_sync;
    // Boot sectors stay locked unless user logic lifts the pin
    next_s.pins.protect_accel = boot_unlock_in;
    if (s.cnt != '0)
    begin
      next_s.cnt = CNT_W'(s.cnt - CNT_LAST);
    end
    unique case (s.st)
      FBOD_ST_IDLE:
      begin
        if (req_valid_in)
        begin
          next_s.op = req_in.op;
          next_s.pins.byte_n = ~req_in.byte_mode;
          next_s.pins.addr = req_in.addr;
          next_s.pins.dq_out = '0;
          next_s.pins.dq_oe = '0;
          if (req_in.op == FBOD_OP_RESET)
          begin
            // Pulse the flash reset pin; the device then returns to array read
            next_s.pins.reset_n = 1'b0;
            next_s.cnt = RP_CYC;
            next_s.st = FBOD_ST_RESET;
          end
          else
          begin
            next_s.pins.ce_n = 1'b0;
            next_s.cnt = SETUP_CYC;
            next_s.st = FBOD_ST_SETUP;
            if (req_in.op == FBOD_OP_PROTECT || req_in.op == FBOD_OP_UNPROTECT)
            begin
              next_s.pins.hv_en = 1'b1;
              next_s.pins.addr = prot_addr;
            end
            if (req_in.op != FBOD_OP_READ)
            begin
              // Output enable is already high here, so driving cannot collide
              next_s.pins.dq_out = req_in.wdata;
              next_s.pins.dq_oe = '1;
            end
            if (req_in.byte_mode)
            begin
              // Upper lanes left to the device; the top pin carries the byte bit
              next_s.pins.dq_oe[TOP_DQ-1:LOW_BYTE_W] = '0;
              next_s.pins.dq_out[TOP_DQ-1:LOW_BYTE_W] = '0;
              next_s.pins.dq_out[TOP_DQ] = req_in.byte_lsb;
              next_s.pins.dq_oe[TOP_DQ] = 1'b1;
            end
          end
        end
      end
      FBOD_ST_SETUP:
      begin
        if (cnt_done)
        begin
          if (s.op == FBOD_OP_READ)
          begin
            next_s.pins.oe_n = 1'b0;
            next_s.cnt = READ_CYC;
            next_s.st = FBOD_ST_READ;
          end
          else
          begin
            // Every command goes in as a plain write cycle
            next_s.pins.we_n = 1'b0;
            next_s.cnt = WP_CYC;
            next_s.st = FBOD_ST_WRITE;
          end
        end
      end
      FBOD_ST_READ:
      begin
        if (cnt_done)
        begin
          // Wait includes the synchroniser delay so the sample is settled
          next_s.rdata = dq_sync;
          if (s.pins.byte_n == 1'b0)
          begin
            next_s.rdata[DATA_W-1:LOW_BYTE_W] = '0;
          end
          next_s.pins.oe_n = 1'b1;
          next_s.cnt = HOLD_CYC;
          next_s.st = FBOD_ST_HOLD;
        end
      end
      FBOD_ST_WRITE:
      begin
        if (cnt_done)
        begin
          // Rising write enable latches address and data in the device
          next_s.pins.we_n = 1'b1;
          next_s.cnt = HOLD_CYC;
          next_s.st = FBOD_ST_HOLD;
        end
      end
      FBOD_ST_HOLD:
      begin
        // Data held past the strobe, and after reads this is bus turnaround
        if (cnt_done)
        begin
          next_s.pins.ce_n = 1'b1;
          next_s.pins.hv_en = 1'b0;
          next_s.pins.dq_oe = '0;
          next_s.pins.dq_out = '0;
          next_s.rsp_valid = 1'b1;
          next_s.st = FBOD_ST_IDLE;
        end
      end
      FBOD_ST_RESET:
      begin
        if (cnt_done)
        begin
          if (s.pins.reset_n == 1'b0)
          begin
            // Release, then wait until reads are allowed again
            next_s.pins.reset_n = 1'b1;
            next_s.cnt = RH_CYC;
          end
          else
          begin
            next_s.rsp_valid = 1'b1;
            next_s.st = FBOD_ST_IDLE;
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      s.st <= FBOD_ST_IDLE;
      s.cnt <= '0;
      s.op <= FBOD_OP_READ;
      s.pins.ce_n <= 1'b1;
      s.pins.oe_n <= 1'b1;
      s.pins.we_n <= 1'b1;
      s.pins.reset_n <= 1'b1;
      s.pins.hv_en <= 1'b0;
      s.pins.byte_n <= 1'b1;
      s.pins.protect_accel <= 1'b0;
      s.pins.addr <= '0;
      s.pins.dq_out <= '0;
      s.pins.dq_oe <= '0;
      s.rdata <= '0;
      s.rsp_valid <= 1'b0;
      s.busy <= 1'b0;
      s.sync_fill <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign req_ready_out = (s.st == FBOD_ST_IDLE);
  assign rsp_valid_out = s.rsp_valid;
  assign rsp_rdata_out = s.rdata;
  assign device_busy_out = s.busy;
  assign pins_out = s.pins;

endmodule
`default_nettype wire

// ---- fbod_host_chk.sv ----
// Pin-level checker for the flash host controller, bound to fbod_host.
// Assumes the single-clock contract and cycle counts of the host controller.
`timescale 1ns/1ps
`default_nettype none

module fbod_host_chk
  import fbod_pkg::*;
(
  // Clock, reset, user level and busy pin
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic boot_unlock_in,
  input wire logic ready_busy_n_in,
  // Watched outputs
  input wire logic rsp_valid_out,
  input wire logic device_busy_out,
  input wire fbod_pins_t pins_out
);
  fbod_pins_t p;
  assign p = pins_out;
  default clocking dc @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  a_read_levels: assert property (!p.oe_n |-> !p.ce_n && p.we_n) else $error("oe low off a read");
  a_write_levels: assert property (!p.we_n |-> !p.ce_n && p.oe_n) else $error("we low off a write");
  a_no_contend: assert property (!p.oe_n |-> p.dq_oe[14:0] == 15'h0000 && (!p.dq_oe[15] || !p.byte_n))
    else $error("host drives in read");
  a_byte_upper: assert property (!p.byte_n |-> p.dq_oe[14:8] == 7'h00) else $error("upper byte driven");
  a_prot_addr: assert property (p.hv_en |-> p.addr[1:0] == 2'h2 && p.reset_n) else $error("bad protect");
  a_accel_copy: assert property (!$past(rst_in) |-> p.protect_accel == $past(boot_unlock_in))
    else $error("protect pin not following");
  a_busy_follow: assert property (!$past(rst_in) && !$past(rst_in, 2) && !$past(rst_in, 3)
    |-> device_busy_out == !$past(ready_busy_n_in, 3)) else $error("busy not following");
  a_read_time: assert property ($fell(p.oe_n) |-> ##8 !p.oe_n ##1 p.oe_n ##2 rsp_valid_out)
    else $error("read timing");
  a_write_time: assert property ($fell(p.we_n) |-> !p.we_n[*4] ##1 p.we_n ##2 rsp_valid_out)
    else $error("write timing");
  a_reset_time: assert property ($fell(p.reset_n) |-> ##49 !p.reset_n ##1 p.reset_n ##5 rsp_valid_out)
    else $error("reset pulse timing");

  c_protect: cover property ($fell(p.we_n) && p.hv_en);
  c_byte_read: cover property ($fell(p.oe_n) && !p.byte_n);
  c_reset: cover property ($fell(p.reset_n));
endmodule

bind fbod_host fbod_host_chk u_fbod_host_chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
  .boot_unlock_in(boot_unlock_in), .ready_busy_n_in(ready_busy_n_in), .rsp_valid_out(rsp_valid_out),
  .device_busy_out(device_busy_out), .pins_out(pins_out));

`default_nettype wire

// ---- fbod_flash_model.sv ----
// Behavioural flash device on the host pins; array word is the address xor a fixed mask.
// Assumes bus_in is the resolved data bus with both parties' enables applied.
`timescale 1ns/1ps
`default_nettype none

module fbod_flash_model
  import fbod_pkg::*;
(
  // Pins from the host
  input wire fbod_pins_t pins_in,
  input wire logic [DATA_W-1:0] bus_in,
  // Pins to the host
  output logic [DATA_W-1:0] dq_out,
  output logic ready_busy_n_out,
  // Observation
  output logic [ADDR_W:0] cmd_addr_out,
  output logic [DATA_W-1:0] cmd_data_out,
  output logic boot_locked_out,
  output var int resets_out
);
  logic [DATA_W-1:0] word;
  logic [DATA_W-1:0] val;
  logic [DATA_W-1:0] last;
  logic drv;
  logic boot_prot;

  initial
  begin
    ready_busy_n_out = 1'b1;
    boot_prot = 1'b1;
    resets_out = 0;
    last = 16'h0000;
    cmd_addr_out = '0;
    cmd_data_out = 16'h0000;
  end

  assign word = pins_in.addr[15:0] ^ 16'hA5C3;
  // Byte mode: lsb selects the byte, upper lanes float so they show a moving pattern
  assign val = pins_in.byte_n ? word : {~word[15:8], bus_in[15] ? word[15:8] : word[7:0]};
  assign drv = pins_in.reset_n && !pins_in.ce_n && !pins_in.oe_n && pins_in.we_n;
  // No pull on the bus, so a released bus shows the inverse of the last driven value
  assign dq_out = drv ? val : ~last;
  always @*
  begin
    if (drv)
    begin
      last = val;
    end
  end
  assign boot_locked_out = !pins_in.protect_accel || boot_prot;

  always @(posedge pins_in.we_n)
  begin
    if (pins_in.reset_n && !pins_in.ce_n && pins_in.oe_n)
    begin
      cmd_addr_out <= {pins_in.addr, pins_in.byte_n ? 1'b0 : bus_in[15]};
      cmd_data_out <= pins_in.byte_n ? bus_in : {8'h00, bus_in[7:0]};
      if (pins_in.hv_en && pins_in.addr[1:0] == 2'h2)
      begin
        boot_prot <= !pins_in.addr[6];
      end
      else
      begin
        ready_busy_n_out <= 1'b0;
        ready_busy_n_out <= #300 1'b1;
      end
    end
  end

  always @(negedge pins_in.reset_n)
  begin
    resets_out <= resets_out + 1;
  end
endmodule

`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench: host controller against the behavioural flash device.
// Assumes the checker and device model are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", n, e, a); end end

module tb_top;
  import fbod_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic vld = 1'b0;
  logic boot_unlock = 1'b0;
  fbod_req_t req = '0;
  logic rdy;
  logic rsp;
  logic busy;
  logic rbn;
  logic locked;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] m_dq;
  logic [DATA_W-1:0] bus;
  logic [DATA_W-1:0] c_data;
  logic [ADDR_W:0] c_addr;
  int resets;
  fbod_pins_t p;
  int num_errors = 0;
  int samples_checked = 0;

  always #5 ref_clk_in = ~ref_clk_in;
  assign bus = (p.dq_oe & p.dq_out) | (~p.dq_oe & m_dq);

  fbod_host u_fbod_host (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .req_valid_in(vld), .req_ready_out(rdy),
    .req_in(req), .rsp_valid_out(rsp), .rsp_rdata_out(rdata), .boot_unlock_in(boot_unlock),
    .device_busy_out(busy), .pins_out(p), .dq_in(bus), .ready_busy_n_in(rbn));
  fbod_flash_model u_fbod_flash_model (.pins_in(p), .bus_in(bus), .dq_out(m_dq), .ready_busy_n_out(rbn),
    .cmd_addr_out(c_addr), .cmd_data_out(c_data), .boot_locked_out(locked), .resets_out(resets));

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  function automatic logic sel(input int k);
    return (k == 0) ? rsp : (k == 1) ? busy : rdy;
  endfunction

  // Bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_sig(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (sel(k) !== v && n < lim)
    begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end
    if (sel(k) !== v)
    begin
      num_errors++;
      $display("wrong value handshake %0d expected %h seen %h", k, v, sel(k));
      give_verdict();
    end
  endtask

  task automatic run(input fbod_op_t op, input logic [ADDR_W-1:0] a, input logic l,
    input logic [DATA_W-1:0] d, input logic b);
    req = '{op, a, l, d, b};
    vld = 1'b1;
    wait_sig(2, 1'b1, 20);
    @(posedge ref_clk_in);
    #1;
    vld = 1'b0;
    wait_sig(0, 1'b1, 100);
  endtask

  task automatic t_read;
    run(FBOD_OP_READ, 21'h012345, 1'b0, 16'h0000, 1'b0);
    `CHK("word read", 16'h2345 ^ 16'hA5C3, rdata)
    run(FBOD_OP_READ, 21'h1FFFFF, 1'b1, 16'h0000, 1'b1);
    `CHK("byte read high", {8'h00, 8'hFF ^ 8'hA5}, rdata)
    run(FBOD_OP_READ, 21'h1FFFFF, 1'b0, 16'h0000, 1'b1);
    `CHK("byte read low", {8'h00, 8'hFF ^ 8'hC3}, rdata)
    $display("read test done");
  endtask

  task automatic t_write;
    run(FBOD_OP_WRITE, 21'h000555, 1'b0, 16'h00AA, 1'b0);
    `CHK("command address", 22'h000AAA, c_addr)
    `CHK("command data", 16'h00AA, c_data)
    run(FBOD_OP_WRITE, 21'h000AAA, 1'b1, 16'h1255, 1'b1);
    `CHK("byte command address", 22'h001555, c_addr)
    `CHK("byte command data", 16'h0055, c_data)
    wait_sig(1, 1'b1, 10);
    `CHK("busy seen", 1'b1, busy)
    wait_sig(1, 1'b0, 60);
    `CHK("busy cleared", 1'b0, busy)
    run(FBOD_OP_READ, 21'h000555, 1'b0, 16'h0000, 1'b0);
    `CHK("read after write", 16'h0555 ^ 16'hA5C3, rdata)
    $display("write test done");
  endtask

  task automatic t_prot;
    boot_unlock = 1'b0;
    run(FBOD_OP_UNPROTECT, 21'h1FF000, 1'b0, 16'h0000, 1'b0);
    `CHK("boot lock pin low", 1'b1, locked)
    boot_unlock = 1'b1;
    repeat (2) @(posedge ref_clk_in);
    #1;
    `CHK("boot after unprotect", 1'b0, locked)
    run(FBOD_OP_PROTECT, 21'h1FF000, 1'b0, 16'h0000, 1'b0);
    `CHK("boot after protect", 1'b1, locked)
    $display("protect test done");
  endtask

  task automatic t_hwrst;
    int n;
    n = resets;
    run(FBOD_OP_RESET, 21'h000000, 1'b0, 16'h0000, 1'b0);
    `CHK("reset pulses", n + 1, resets)
    run(FBOD_OP_READ, 21'h000000, 1'b0, 16'h0000, 1'b0);
    `CHK("read after reset", 16'hA5C3, rdata)
    $display("reset test done");
  endtask

  initial
  begin
    repeat (20) @(posedge ref_clk_in);
    #1;
    rst_in = 1'b0;
    t_read();
    t_write();
    t_prot();
    t_hwrst();
    give_verdict();
  end
endmodule

`default_nettype wire
